// file: hdl/ettc_top.sv
// two-channel 8-bit timer/event counter with compare, pwm and timer output flop
// assumes one 100 MHz clock, cpu accesses one cycle wide, timer pins asynchronous
`timescale 1ns/1ps

module ettc_top #(
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire ettc_pkg::ettc_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic [1:0]        timer_pin_in,
  input  wire logic [1:0]        port_data,
  input  wire logic [1:0]        port_oe,
  output logic [1:0]             timer_pin_out,
  output logic [1:0]             timer_pin_oe,
  output logic [1:0]             match_irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8)
  begin : g_bad_width
    $error("counter width must be 8");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // release is clocked so no flop leaves reset mid-edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // access decode shared by both channels
  // ----------------------------------------------------------------
  logic [7:0] bit_mask;
  logic [7:0] cmd_data;
  logic       any_wr;

  assign any_wr   = bus.wr | bus.wr_bit;
  assign bit_mask = bus.wr_bit ? (8'h01 << bus.bit_sel) : 8'hFF;
  // bit writes carry the bit value in wdata[0]; place it at its position
  assign cmd_data = bus.wr_bit ? ({7'h00, bus.wdata[0]} << bus.bit_sel) : bus.wdata;

  logic [7:0] rd_val [0:1];
  logic [1:0] rd_hit;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    // prescaler width is declared first, the flops below are sized by it
    localparam int PRE_W_L = ettc_pkg::PRE_W;

    logic [15:0] a_sel;
    logic [15:0] a_mode;
    logic [15:0] a_cnt;
    logic [15:0] a_match;
    logic [7:0]  sel_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  mode_next;
    logic [7:0]  match_reg;
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic [PRE_W_L-1:0] pre_reg;
    logic [2:0]  pin_sync_reg;
    logic        hold_reg;
    logic        flop_reg;
    logic        pwm_act_reg;
    logic        irq_reg;
    logic        out_reg;
    logic        oe_reg;
    logic        sel_wr;
    logic        mode_wr;
    logic        match_wr;
    logic        cnt_rd;
    logic        cen;
    logic        pwm;
    logic        inv;
    logic [3:0]  expo;
    logic [PRE_W_L-1:0] pre_mask;
    logic        pre_tick;
    logic        pin_rise;
    logic        pin_fall;
    logic        src_tick;
    logic        step_raw;
    logic        step;
    logic        hit;
    logic        ovf;
    logic        do_preset;
    logic        do_clear;
    logic        pin_level;

    assign a_sel   = ch == 0 ? ettc_pkg::ADDR_CLK_SEL_A : ettc_pkg::ADDR_CLK_SEL_B;
    assign a_mode  = ch == 0 ? ettc_pkg::ADDR_MODE_A : ettc_pkg::ADDR_MODE_B;
    assign a_cnt   = ch == 0 ? ettc_pkg::ADDR_COUNT_A : ettc_pkg::ADDR_COUNT_B;
    assign a_match = ch == 0 ? ettc_pkg::ADDR_MATCH_A : ettc_pkg::ADDR_MATCH_B;

    // register strobes
    assign sel_wr   = bus.wr && bus.addr == a_sel;
    assign mode_wr  = any_wr && bus.addr == a_mode;
    assign match_wr = any_wr && bus.addr == a_match;
    assign cnt_rd   = bus.rd && bus.addr == a_cnt;

    // mode fields
    assign cen = mode_reg[ettc_pkg::BIT_CEN];
    assign pwm = mode_reg[ettc_pkg::BIT_PWM];
    assign inv = mode_reg[ettc_pkg::BIT_INV];
    assign mode_next = ((mode_reg & ~bit_mask) | (cmd_data & bit_mask))
                       & ettc_pkg::MODE_STORE_MASK;
    // commands act only on the bits this write actually carries
    assign do_preset = mode_wr && bit_mask[ettc_pkg::BIT_PRESET]
                       && cmd_data[ettc_pkg::BIT_PRESET]
                       && !(bit_mask[ettc_pkg::BIT_CLEAR] && cmd_data[ettc_pkg::BIT_CLEAR]);
    assign do_clear  = mode_wr && bit_mask[ettc_pkg::BIT_CLEAR]
                       && cmd_data[ettc_pkg::BIT_CLEAR]
                       && !(bit_mask[ettc_pkg::BIT_PRESET] && cmd_data[ettc_pkg::BIT_PRESET]);

    // clock source selection
    assign expo     = ch == 0 ? ettc_pkg::EXP_UNIT_A[sel_reg[2:0]]
                              : ettc_pkg::EXP_UNIT_B[sel_reg[2:0]];
    assign pre_mask = PRE_W_L'((1 << expo) - 1);
    assign pre_tick = (pre_reg & pre_mask) == pre_mask;
    assign pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];
    assign pin_fall = ~pin_sync_reg[1] & pin_sync_reg[2];
    assign src_tick = sel_reg[2:0] == ettc_pkg::SEL_PIN_FALL ? pin_fall :
                      sel_reg[2:0] == ettc_pkg::SEL_PIN_RISE ? pin_rise : pre_tick;
    // a pending step from a read cycle is released next cycle
    assign step_raw = cen && (src_tick || hold_reg);
    assign step     = step_raw && !cnt_rd;

    // compare is always live against the current match value
    assign hit = cnt_reg == match_reg;
    assign ovf = cnt_reg == 8'hFF;
    always_comb
    begin
      cnt_next = cnt_reg;
      if (!cen)
        cnt_next = 8'h00;
      else if (step && !pwm && hit)
        cnt_next = 8'h00;
      else if (step)
        cnt_next = cnt_reg + 8'h01;
    end

    // pwm waveform active level is inverted by the polarity bit
    assign pin_level = pwm ? (pwm_act_reg ^ inv) : flop_reg;

    // synchroniser for the asynchronous pin; stage 0 feeds stage 1 only
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_sync_reg <= 3'h0;
      else
        pin_sync_reg <= {pin_sync_reg[1:0], timer_pin_in[ch]};
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sel_reg   <= ettc_pkg::CLK_SEL_RST;
        mode_reg  <= ettc_pkg::MODE_RST;
        match_reg <= ettc_pkg::MATCH_RST;
      end
      else
      begin
        if (sel_wr)
          sel_reg <= bus.wdata & ettc_pkg::CLK_SEL_MASK;
        if (mode_wr)
          mode_reg <= mode_next;
        if (match_wr)
          match_reg <= bus.wr_bit ? ((match_reg & ~bit_mask) | cmd_data) : bus.wdata;
      end
    end

    // prescaler runs only while counting is enabled
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pre_reg <= '0;
      else if (!cen)
        pre_reg <= '0;
      else
        pre_reg <= pre_reg + PRE_W_L'(1);
    end

    // counter and read hold-off
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_reg  <= 8'h00;
        hold_reg <= 1'b0;
      end
      else
      begin
        cnt_reg  <= cnt_next;
        hold_reg <= step_raw && cnt_rd;
      end
    end

    // match request, one cycle per match outside pwm
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        irq_reg <= 1'b0;
      else
        irq_reg <= cen && step && !pwm && hit;
    end

    // output flop: write commands, toggle on match outside pwm while the inv bit is set
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        flop_reg <= 1'b0;
      else if (do_preset)
        flop_reg <= 1'b1;
      else if (do_clear)
        flop_reg <= 1'b0;
      else if (step && !pwm && hit && inv)
        flop_reg <= ~flop_reg;
    end

    // pwm phase: active from overflow until match, dropped when stopped
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pwm_act_reg <= 1'b0;
      else if (!cen || !pwm)
        pwm_act_reg <= 1'b0;
      else if (step && ovf)
        pwm_act_reg <= 1'b1;
      else if (step && hit)
        pwm_act_reg <= 1'b0;
    end

    // pin mux; port logic keeps the pin while the timer output is off
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        out_reg <= 1'b0;
        oe_reg  <= 1'b0;
      end
      else if (mode_reg[ettc_pkg::BIT_PIN_EN])
      begin
        out_reg <= pin_level;
        oe_reg  <= 1'b1;
      end
      else
      begin
        out_reg <= port_data[ch];
        oe_reg  <= port_oe[ch];
      end
    end

    // read data for this channel; command bits read back as zero
    assign rd_hit[ch] = bus.addr == a_sel || bus.addr == a_mode
                        || bus.addr == a_cnt || bus.addr == a_match;
    assign rd_val[ch] = bus.addr == a_sel   ? sel_reg :
                        bus.addr == a_mode  ? (mode_reg & ettc_pkg::MODE_READ_MASK) :
                        bus.addr == a_cnt   ? cnt_reg :
                        bus.addr == a_match ? match_reg : 8'h00;

    assign timer_pin_out[ch] = out_reg;
    assign timer_pin_oe[ch]  = oe_reg;
    assign match_irq[ch]     = irq_reg;
  end

  // ----------------------------------------------------------------
  // read port: unmapped addresses read zero
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  assign rdata_next = !bus.rd    ? rdata_reg :
                      rd_hit[0]  ? rd_val[0] :
                      rd_hit[1]  ? rd_val[1] : 8'h00;

  // data stands until the next read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end
  assign rdata = rdata_reg;

endmodule

// file: include/ettc_pkg.sv
// shared constants and carrier types of the two-channel 8-bit timer/event counter
// assumes a cpu data-space port with byte and single-bit writes
package ettc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CLK_SEL_A  = 16'hFF74;
  localparam logic [15:0] ADDR_CLK_SEL_B  = 16'hFF75;
  localparam logic [15:0] ADDR_MODE_A     = 16'hFF77;
  localparam logic [15:0] ADDR_MODE_B     = 16'hFF78;
  localparam logic [15:0] ADDR_COUNT_A    = 16'hFF70;
  localparam logic [15:0] ADDR_COUNT_B    = 16'hFF71;
  localparam logic [15:0] ADDR_MATCH_A    = 16'hFF72;
  localparam logic [15:0] ADDR_MATCH_B    = 16'hFF79;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST        = 8'h04;
  localparam logic [7:0] CLK_SEL_RST     = 8'h00;
  localparam logic [7:0] MATCH_RST       = 8'h00;
  localparam logic [7:0] MODE_READ_MASK  = 8'hC3;
  localparam logic [7:0] MODE_STORE_MASK = 8'hCF;
  localparam logic [7:0] CLK_SEL_MASK    = 8'h07;
  localparam int         BIT_CEN         = 7;
  localparam int         BIT_PWM         = 6;
  localparam int         BIT_PRESET      = 3;
  localparam int         BIT_CLEAR       = 2;
  localparam int         BIT_INV         = 1;
  localparam int         BIT_PIN_EN      = 0;

  // ----------------------------------------------------------------
  // clock selector codes and prescaler exponents for codes 2..7
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_PIN_FALL = 3'h0;
  localparam logic [2:0] SEL_PIN_RISE = 3'h1;
  localparam int         PRE_W        = 12;
  typedef logic [3:0] ettc_exp_t [0:7];
  localparam ettc_exp_t EXP_UNIT_A = '{4'h0, 4'h0, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hB};
  localparam ettc_exp_t EXP_UNIT_B = '{4'h0, 4'h0, 4'h4, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC};

  // ----------------------------------------------------------------
  // cpu access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  bit_sel;
    logic        wr;
    logic        wr_bit;
    logic        rd;
  } ettc_bus_t;

endpackage

// file: test/ettc_checker.sv
// checker for the timer block: unit a mode writes, pin drive, match pulses, reads
// assumes one clock and the byte and bit write strobes of ettc_pkg
`timescale 1ns/1ps
module ettc_checker (
  input wire logic                clk,
  input wire logic                nrst,
  input wire ettc_pkg::ettc_bus_t bus,
  input wire logic [7:0]          rdata,
  input wire logic [1:0]          timer_pin_in,
  input wire logic [1:0]          port_data,
  input wire logic [1:0]          port_oe,
  input wire logic [1:0]          timer_pin_out,
  input wire logic [1:0]          timer_pin_oe,
  input wire logic [1:0]          match_irq
);
  // ---------------------------------------------
  // shadow of the unit a mode byte
  // ---------------------------------------------
  logic [7:0] mode_reg;
  wire        hit_mode = bus.addr == ettc_pkg::ADDR_MODE_A;
  wire        hit_cnt  = bus.addr == ettc_pkg::ADDR_COUNT_A;
  wire        cmd_wr   = bus.wr && hit_mode && bus.wdata[7:6] == 2'h0 && bus.wdata[1:0] == 2'h1;
  // only the bits the properties use need to be exact, so no store mask here
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      mode_reg <= ettc_pkg::MODE_RST;
    else if (bus.wr && hit_mode)
      mode_reg <= bus.wdata;
    else if (bus.wr_bit && hit_mode)
      mode_reg[bus.bit_sel] <= bus.wdata[0];
  // unit b shadow; only its pin enable bit is watched
  logic [7:0] mode_b_reg;
  wire        hit_mode_b = bus.addr == ettc_pkg::ADDR_MODE_B;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      mode_b_reg <= ettc_pkg::MODE_RST;
    else if (bus.wr && hit_mode_b)
      mode_b_reg <= bus.wdata;
    else if (bus.wr_bit && hit_mode_b)
      mode_b_reg[bus.bit_sel] <= bus.wdata[0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_irq_one_cycle: assert property (match_irq[0] |=> !match_irq[0])
    else $error("match pulse too long");
  a_cmd_reads_zero: assert property (bus.rd && hit_mode |=> rdata[3:2] == 2'h0)
    else $error("command bits read back");
  a_port_owns_pin: assert property (!mode_reg[0] |=>
    timer_pin_oe[0] == $past(port_oe[0]) && timer_pin_out[0] == $past(port_data[0]))
    else $error("port drive lost");
  a_timer_owns_pin: assert property (mode_reg[0] |=> timer_pin_oe[0])
    else $error("timer output not driving");
  a_port_owns_b: assert property (!mode_b_reg[0] |=>
    timer_pin_oe[1] == $past(port_oe[1]) && timer_pin_out[1] == $past(port_data[1]))
    else $error("unit b port drive lost");
  a_timer_owns_b: assert property (mode_b_reg[0] |=> timer_pin_oe[1])
    else $error("unit b timer output not driving");
  a_stop_clears: assert property (bus.rd && hit_cnt && !mode_reg[7] &&
    !$past(mode_reg[7]) |=> rdata == 8'h00)
    else $error("stopped counter not zero");
  a_pwm_quiet: assert property (mode_reg[6] && $past(mode_reg[6]) |=> !match_irq[0])
    else $error("match pulse in pwm mode");
  a_idle_quiet: assert property (!mode_reg[7] && !$past(mode_reg[7]) |=> !match_irq[0])
    else $error("match pulse while stopped");
  a_preset_sets: assert property (cmd_wr && bus.wdata[3:2] == 2'h2 |->
    ##[2:3] timer_pin_out[0])
    else $error("preset did not raise output");
  a_clear_resets: assert property (cmd_wr && bus.wdata[3:2] == 2'h1 |->
    ##[2:3] !timer_pin_out[0])
    else $error("clear did not lower output");
endmodule
bind ettc_top ettc_checker i_ettc_checker (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
  .timer_pin_in(timer_pin_in), .port_data(port_data), .port_oe(port_oe),
  .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .match_irq(match_irq));

// file: test/ettc_pin_model.sv
// outside event source and load on the two timer pins
// assumes pin drive and enable come registered from the clk domain
`timescale 1ns/1ps
module ettc_pin_model (
  input wire logic [1:0] drv_out,
  input wire logic [1:0] drv_oe,
  input wire logic [1:0] port_data,
  input wire logic [1:0] port_oe,
  input wire logic       clk,
  output logic [1:0]     pin
);
  logic [1:0] ext_lvl = 2'h0;
  // timer drive wins, then the port latch, then the outside source
  assign pin = (drv_oe & drv_out) | (~drv_oe & port_oe & port_data) | (~drv_oe & ~port_oe & ext_lvl);
  // five cycles per level so the three-flop synchroniser sees every edge
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      ext_lvl[ch] = 1'b1;
      repeat (5) @(negedge clk);
      ext_lvl[ch] = 1'b0;
      repeat (5) @(negedge clk);
    end
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the two-channel timer/event counter
// assumes ettc_top, the pin model and the bound checker are compiled before it
`timescale 1ns/1ps
module tb;
  logic                clk = 1'b0;
  logic                nrst;
  ettc_pkg::ettc_bus_t bus;
  logic [7:0]          rdata;
  logic [1:0]          pin;
  logic [1:0]          port_data;
  logic [1:0]          port_oe;
  logic [1:0]          pin_out;
  logic [1:0]          pin_oe;
  logic [1:0]          irq;
  logic                rd_seen = 1'b0;
  logic [7:0]          q_rd[$];
  int                  q_irq[$];
  int                  q_w[$];
  int                  miscompares = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  int                  last_irq = 0;
  int                  hi_cnt = 0;
  int                  m;
  int                  ea[8] = '{0, 0, 3, 5, 7, 8, 9, 11};
  int                  eb[8] = '{0, 0, 4, 6, 7, 8, 10, 12};
  ettc_top i_ettc_top (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .timer_pin_in(pin),
    .port_data(port_data), .port_oe(port_oe), .timer_pin_out(pin_out),
    .timer_pin_oe(pin_oe), .match_irq(irq));
  ettc_pin_model i_ettc_pin_model (.drv_out(pin_out), .drv_oe(pin_oe), .port_data(port_data),
    .port_oe(port_oe), .clk(clk), .pin(pin));
  always #5 clk = ~clk;
  // ---------------------------------------------
  // compare and report
  // ---------------------------------------------
  task automatic fail(input string msg);
    miscompares++;
    $display("wrong value at %0t ns: %s", $time, msg);
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
      fail($sformatf("read %h, wanted %h", g, e));
  endtask
  // note holds the channel above bit 16 and the gap in cycles below, 0 meaning any gap
  task automatic chk_irq(input logic [1:0] g, input int n, input int gap);
    num_checks++;
    if (g !== 2'(1 << (n >> 16)) || (n[15:0] != 0 && gap != n[15:0]))
      fail($sformatf("match %b after %0d, note %h", g, gap, n));
  endtask
  // a negative note only lets a partial first pulse go by
  task automatic chk_w(input int g, input int e);
    if (e >= 0)
      num_checks++;
    if (e >= 0 && g != e)
      fail($sformatf("pin high %0d cycles, wanted %0d", g, e));
  endtask
  task automatic summarize();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watcher: each read answer, and each match pulse or pin 0 high time while a note waits, meets its oldest note
  always @(posedge clk)
    rd_seen <= bus.rd;
  always @(negedge clk)
  begin
    cyc++;
    if (rd_seen && q_rd.size() > 0)
      chk_rd(rdata, q_rd.pop_front());
    if (irq !== 2'h0 && q_irq.size() > 0)
      chk_irq(irq, q_irq.pop_front(), cyc - last_irq);
    if (irq !== 2'h0)
      last_irq = cyc;
    if (pin_out[0] === 1'b1)
      hi_cnt++;
    else if (hi_cnt > 0 && q_w.size() > 0)
      chk_w(hi_cnt, q_w.pop_front());
    if (pin_out[0] !== 1'b1)
      hi_cnt = 0;
  end
  // ---------------------------------------------
  // cpu accesses, one strobe edge then a quiet cycle so strobes never collide
  // ---------------------------------------------
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic [2:0] bs,
                     input logic [2:0] kind);
    bus = {a, d, bs, kind};
    @(negedge clk);
    bus[2:0] = 3'h0;
    @(negedge clk);
  endtask
  task automatic wrb(input logic [15:0] a, input logic [7:0] d);
    acc(a, d, 3'h0, 3'h4);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    acc(a, 8'h00, 3'h0, 3'h1);
  endtask
  task automatic drain(input int lim);
    int n = 0;
    while (q_irq.size() + q_w.size() > 0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    // a result that lands on the last cycle of the limit is not a timeout
    if (q_irq.size() + q_w.size() > 0)
      fail("no result in time");
    if (q_irq.size() + q_w.size() > 0)
      summarize();
  endtask
  // stop, pick a source, then count pin pulses or time two prescaled match pulses
  task automatic run_src(input int ch, input int code);
    logic [15:0] am = ettc_pkg::ADDR_MODE_A + 16'(ch);
    logic [15:0] ac = ettc_pkg::ADDR_COUNT_A + 16'(ch);
    int          k  = ch ? eb[code] : ea[code];
    wrb(am, 8'h00);
    wrb(ettc_pkg::ADDR_CLK_SEL_A + 16'(ch), 8'(code));
    wrb(ch ? ettc_pkg::ADDR_MATCH_B : ettc_pkg::ADDR_MATCH_A, code < 2 ? 8'h03 : 8'h00);
    wrb(am, 8'h80);
    if (code < 2)
    begin
      i_ettc_pin_model.pulse(ch, 3);
      rd(ac, 8'h03);
      q_irq.push_back(ch << 16);
      i_ettc_pin_model.pulse(ch, 1);
      drain(100);
      rd(ac, 8'h00);
    end
    else
    begin
      q_irq.push_back(ch << 16);
      q_irq.push_back(ch << 16 | 1 << k);
      drain(4 << k);
    end
    wrb(am, 8'h00);
    rd(ac, 8'h00);
  endtask
  initial
  begin
    nrst = 1'b0;
    bus = '0;
    port_data = 2'h0;
    port_oe = 2'h0;
    m = $urandom(32'h748F);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(ettc_pkg::ADDR_MODE_A, 8'h00);
    rd(ettc_pkg::ADDR_CLK_SEL_B, 8'h00);
    rd(16'hFF7F, 8'h00);
    wrb(ettc_pkg::ADDR_MODE_B, 8'h4B);
    rd(ettc_pkg::ADDR_MODE_B, 8'h43);
    acc(ettc_pkg::ADDR_MODE_B, 8'h01, 3'h7, 3'h2);
    rd(ettc_pkg::ADDR_MODE_B, 8'hC3);
    acc(ettc_pkg::ADDR_CLK_SEL_A, 8'h01, 3'h1, 3'h2);
    rd(ettc_pkg::ADDR_CLK_SEL_A, 8'h00);
    wrb(ettc_pkg::ADDR_MODE_B, 8'h00);
    $display("register test done");
    repeat (20)
    begin
      port_data = 2'($urandom);
      port_oe = 2'($urandom);
      @(negedge clk);
    end
    // park the port low first, else a stale high level adds to the preset pulse
    port_data = 2'h0;
    port_oe = 2'h0;
    repeat (2) @(negedge clk);
    q_w.push_back(12);
    wrb(ettc_pkg::ADDR_MODE_A, 8'h09);
    repeat (10) @(negedge clk);
    wrb(ettc_pkg::ADDR_MODE_A, 8'h05);
    drain(50);
    $display("pin control test done");
    for (int ch = 0; ch < 2; ch++)
      for (int code = 0; code < 8; code++)
        run_src(ch, code);
    $display("clock source test done");
    wrb(ettc_pkg::ADDR_MATCH_A, 8'h03);
    wrb(ettc_pkg::ADDR_CLK_SEL_A, 8'h02);
    wrb(ettc_pkg::ADDR_MODE_A, 8'h83);
    q_w.push_back(-1);
    q_w.push_back(32);
    drain(300);
    m = $urandom_range(209, 10);
    wrb(ettc_pkg::ADDR_MODE_A, 8'h05);
    wrb(ettc_pkg::ADDR_MODE_A, 8'hC1);
    wrb(ettc_pkg::ADDR_MATCH_A, 8'(m));
    q_w.push_back(-1);
    q_w.push_back((m + 1) * 8);
    drain(8000);
    wrb(ettc_pkg::ADDR_MODE_A, 8'h01);
    wrb(ettc_pkg::ADDR_MODE_A, 8'hC3);
    q_w.push_back(-1);
    q_w.push_back((255 - m) * 8);
    drain(8000);
    $display("waveform test done");
    summarize();
  end
endmodule
